// >>> hdl/dcr_pkg.sv
// Shared constants and types for the DMA channel configuration registers
package dcr_pkg;

  // ==========================================================
  // Bus geometry
  localparam int          DCR_ADDR_W   = 18;
  localparam int          DCR_DATA_W   = 32;
  localparam int          DCR_REG_W    = 8;

  // ==========================================================
  // Register indices and byte addresses (index times four)
  localparam logic [15:0] DCR_CTL_IDX  = 16'hffee;
  localparam logic [15:0] DCR_HI_IDX   = 16'hffef;
  localparam logic [17:0] DCR_CTL_ADDR = {DCR_CTL_IDX, 2'b00};
  localparam logic [17:0] DCR_HI_ADDR  = {DCR_HI_IDX, 2'b00};

  // ==========================================================
  // Control register fields
  localparam int          DCR_EN_BIT   = 7;
  localparam int          DCR_WRAP_BIT = 6;
  localparam int          DCR_DIR_BIT  = 3;
  localparam int          DCR_EP_LSB   = 0;
  localparam int          DCR_EP_W     = 3;

  // ==========================================================
  // Slot high register fields
  localparam int          DCR_BPS_LSB  = 6;
  localparam int          DCR_BPS_W    = 2;
  localparam int          DCR_HI_LSB   = 0;
  localparam int          DCR_HI_W     = 6;
  localparam int          DCR_LO_W     = 8;
  localparam int          DCR_SLOTS    = 14;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  DCR_CTL_RST  = 8'h00;
  localparam logic [7:0]  DCR_HI_RST   = 8'h00;
  localparam logic [7:0]  DCR_LO_RST   = 8'h00;

  // ==========================================================
  // Configuration as seen by the transfer engine
  typedef struct packed {
    logic        chan_en;
    logic        wrap_en;
    logic        ep_dir;
    logic [2:0]  ep_num;
    logic [1:0]  bytes_code;
    logic [13:0] slot_mask;
  } dcr_cfg_t;

endpackage

// >>> hdl/dcr_dma_cfg_regs.sv
// Configuration registers and slot sequencer of one DMA channel
//
// Operation
// - Bytes code 00b..11b gives one to four bytes
// - Slot high bits 5:0 select slots 8-13
// - Enable bit 7 starts or stops transfers
// - Bit 6 turns wrap buffer on or off
// - Wrap only for isochronous endpoints
// - Wrap setting is private to this channel
// - Wrap goes to engine and buffer manager
// - Bit 3 selects in or out direction
// - Bits 2:0 name endpoint one to seven
// - Control bits 5:4 always read zero
// - Fourteen-bit mask, low byte from companion register
// - Selected slots move bytes in set direction
//
// Added by the designer: the Avalon-MM interface to the registers.
module dcr_dma_cfg_regs
  import dcr_pkg::*;
(
  input  wire logic                  REF_CLK_I,
  input  wire logic                  NRST_I,
  input  wire logic [DCR_ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                  AVS_READ_I,
  input  wire logic                  AVS_WRITE_I,
  input  wire logic [DCR_DATA_W-1:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]            AVS_BYTEENABLE_I,
  input  wire logic [DCR_LO_W-1:0]   SLOT_LOW_I,
  input  wire logic                  SLOT_STROBE_I,
  input  wire logic [3:0]            SLOT_INDEX_I,
  output logic      [DCR_DATA_W-1:0] AVS_READDATA_O,
  output logic                       AVS_WAITREQUEST_O,
  output dcr_cfg_t                   CFG_O,
  output logic                       MGR_WRAP_O,
  output logic                       SLOT_SERVE_O,
  output logic      [2:0]            BYTE_COUNT_O,
  output logic                       XFER_REQ_O,
  output logic                       XFER_DIR_O
);

  // ==========================================================
  // Storage
  logic                  wait_reg;
  logic                  wait_next;
  logic [DCR_DATA_W-1:0] rdata_reg;
  logic [DCR_DATA_W-1:0] rdata_next;
  logic                  en_reg;
  logic                  wrap_reg;
  logic                  mgr_wrap_reg;
  logic                  dir_reg;
  logic [DCR_EP_W-1:0]   ep_reg;
  logic [DCR_BPS_W-1:0]  bps_reg;
  logic [DCR_HI_W-1:0]   hi_reg;
  logic [DCR_LO_W-1:0]   lo_reg;
  logic [2:0]            bytes_reg;
  logic                  serve_reg;
  logic                  serve_next;
  logic [2:0]            beats_reg;
  logic [2:0]            beats_next;
  logic                  xreq_reg;
  logic                  xdir_reg;
  logic                  req;
  logic                  done;
  logic                  hit_ctl;
  logic                  hit_hi;
  logic                  wr_ctl;
  logic                  wr_hi;
  logic [7:0]            ctl_view;
  logic [7:0]            hi_view;
  logic [DCR_SLOTS-1:0]  mask;

  // ==========================================================
  // Bus decode
  assign req     = AVS_READ_I | AVS_WRITE_I;
  assign done    = req & ~wait_reg;
  assign hit_ctl = (AVS_ADDRESS_I == DCR_CTL_ADDR);
  assign hit_hi  = (AVS_ADDRESS_I == DCR_HI_ADDR);
  assign wr_ctl  = AVS_WRITE_I & done & hit_ctl & AVS_BYTEENABLE_I[0];
  assign wr_hi   = AVS_WRITE_I & done & hit_hi & AVS_BYTEENABLE_I[0];

  assign ctl_view = {en_reg, wrap_reg, 2'b00, dir_reg, ep_reg};
  assign hi_view  = {bps_reg, hi_reg};

  assign mask = {hi_reg, lo_reg};

  // ==========================================================
  // Wait state: one wait cycle, then a one-cycle answer
  always_comb
  begin
    wait_next = 1'b1;
    if (req && wait_reg)
    begin
      wait_next = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      wait_reg <= 1'b1;
    end
    else
    begin
      wait_reg <= wait_next;
    end
  end

  // ==========================================================
  // Read data, loaded in the wait cycle so it stands at the answer
  always_comb
  begin
    rdata_next = '0;
    if (AVS_READ_I && wait_reg)
    begin
      if (hit_ctl)
      begin
        rdata_next = {24'h00_0000, ctl_view};
      end
      else if (hit_hi)
      begin
        rdata_next = {24'h00_0000, hi_view};
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rdata_reg <= '0;
    end
    else if (wait_reg)
    begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      en_reg       <= DCR_CTL_RST[DCR_EN_BIT];
      wrap_reg     <= DCR_CTL_RST[DCR_WRAP_BIT];
      mgr_wrap_reg <= DCR_CTL_RST[DCR_WRAP_BIT];
      dir_reg      <= DCR_CTL_RST[DCR_DIR_BIT];
      ep_reg       <= DCR_CTL_RST[DCR_EP_LSB +: DCR_EP_W];
    end
    else if (wr_ctl)
    begin
      en_reg       <= AVS_WRITEDATA_I[DCR_EN_BIT];
      wrap_reg     <= AVS_WRITEDATA_I[DCR_WRAP_BIT];
      mgr_wrap_reg <= AVS_WRITEDATA_I[DCR_WRAP_BIT];
      dir_reg      <= AVS_WRITEDATA_I[DCR_DIR_BIT];
      ep_reg       <= AVS_WRITEDATA_I[DCR_EP_LSB +: DCR_EP_W];
    end
  end

  // ==========================================================
  // Slot high register
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      bps_reg <= DCR_HI_RST[DCR_BPS_LSB +: DCR_BPS_W];
      hi_reg  <= DCR_HI_RST[DCR_HI_LSB +: DCR_HI_W];
    end
    else if (wr_hi)
    begin
      bps_reg <= AVS_WRITEDATA_I[DCR_BPS_LSB +: DCR_BPS_W];
      hi_reg  <= AVS_WRITEDATA_I[DCR_HI_LSB +: DCR_HI_W];
    end
  end

  // ==========================================================
  // Low slot byte from the companion register, same clock
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      lo_reg <= DCR_LO_RST;
    end
    else
    begin
      lo_reg <= SLOT_LOW_I;
    end
  end

  // ==========================================================
  // Bytes per slot as a count
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      bytes_reg <= 3'h1;
    end
    else
    begin
      bytes_reg <= {1'b0, bps_reg} + 3'h1;
    end
  end

  // ==========================================================
  // Slot sequencer: one request per byte of each selected slot
  always_comb
  begin
    serve_next = 1'b0;
    if (SLOT_STROBE_I && en_reg && (SLOT_INDEX_I < 4'(DCR_SLOTS)))
    begin
      serve_next = mask[SLOT_INDEX_I];
    end
  end

  // A new slot restarts the count; the codec frame leaves room for it
  always_comb
  begin
    beats_next = beats_reg;
    if (serve_next)
    begin
      beats_next = bytes_reg;
    end
    else if (beats_reg != 3'h0)
    begin
      beats_next = beats_reg - 3'h1;
    end
    if (!en_reg)
    begin
      beats_next = 3'h0;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      serve_reg <= 1'b0;
      beats_reg <= 3'h0;
    end
    else
    begin
      serve_reg <= serve_next;
      beats_reg <= beats_next;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      xreq_reg <= 1'b0;
      xdir_reg <= 1'b0;
    end
    else
    begin
      xreq_reg <= (beats_reg != 3'h0) && en_reg;
      xdir_reg <= dir_reg;
    end
  end

  // ==========================================================
  // Outputs
  assign AVS_WAITREQUEST_O = wait_reg;
  assign AVS_READDATA_O    = rdata_reg;
  assign CFG_O             = '{chan_en:    en_reg,
                               wrap_en:    wrap_reg,
                               ep_dir:     dir_reg,
                               ep_num:     ep_reg,
                               bytes_code: bps_reg,
                               slot_mask:  mask};
  assign MGR_WRAP_O        = mgr_wrap_reg;
  assign SLOT_SERVE_O      = serve_reg;
  assign BYTE_COUNT_O      = bytes_reg;
  assign XFER_REQ_O        = xreq_reg;
  assign XFER_DIR_O        = xdir_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  property p_bytes_count;
    ##1 BYTE_COUNT_O == ({1'b0, $past(bps_reg)} + 3'h1);
  endproperty
  a_bytes_count: assert property (p_bytes_count)
    else $error("byte count does not follow bytes code");

  property p_slot_high;
    wr_hi |=> (CFG_O.slot_mask[13:8] == $past(AVS_WRITEDATA_I[5:0]));
  endproperty
  a_slot_high: assert property (p_slot_high)
    else $error("upper slot bits not stored");

  property p_enable;
    wr_ctl |=> (CFG_O.chan_en == $past(AVS_WRITEDATA_I[7]));
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable bit not stored");

  property p_wrap;
    wr_ctl |=> (CFG_O.wrap_en == $past(AVS_WRITEDATA_I[6]));
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap bit not stored");

  property p_wrap_own;
    !wr_ctl |=> $stable(CFG_O.wrap_en);
  endproperty
  a_wrap_own: assert property (p_wrap_own)
    else $error("wrap bit changed without control write");

  property p_wrap_route;
    MGR_WRAP_O == CFG_O.wrap_en;
  endproperty
  a_wrap_route: assert property (p_wrap_route)
    else $error("wrap copies disagree");

  property p_dir_ep;
    wr_ctl |=> (CFG_O.ep_dir == $past(AVS_WRITEDATA_I[3]))
               && (CFG_O.ep_num == $past(AVS_WRITEDATA_I[2:0]));
  endproperty
  a_dir_ep: assert property (p_dir_ep)
    else $error("direction or endpoint not stored");

  property p_reserved;
    (AVS_READ_I && !AVS_WAITREQUEST_O && hit_ctl) |-> (AVS_READDATA_O[5:4] == 2'b00);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits read nonzero");

  property p_low_mask;
    ##1 CFG_O.slot_mask[7:0] == $past(SLOT_LOW_I);
  endproperty
  a_low_mask: assert property (p_low_mask)
    else $error("low slot byte not captured");

  property p_serve;
    (SLOT_STROBE_I && en_reg && SLOT_INDEX_I < 4'd14 && mask[SLOT_INDEX_I])
      |=> SLOT_SERVE_O ##1 XFER_REQ_O;
  endproperty
  a_serve: assert property (p_serve)
    else $error("selected slot not served");

  property p_idle;
    !en_reg |=> !SLOT_SERVE_O;
  endproperty
  a_idle: assert property (p_idle)
    else $error("disabled channel served a slot");

  property p_answer;
    (req && AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not one wait cycle");

endmodule

// >>> sim/dcr_far_model.sv
// Behavioural codec port and buffer manager side of one DMA channel
module dcr_far_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       fire_i,
  input  wire logic [3:0] idx_i,
  input  wire logic       serve_i,
  input  wire logic       req_i,
  input  wire logic       dir_i,
  output logic            strobe_o,
  output logic      [3:0] index_o,
  output logic      [3:0] served_o,
  output logic      [3:0] beats_o,
  output logic            dir_o
);
  // ==========================================================
  // Slot start strobe
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strobe_o <= 1'b0;
      index_o  <= 4'h0;
    end
    else
    begin
      strobe_o <= fire_i;
      // Index means nothing between strobes, so it keeps toggling there
      index_o  <= fire_i ? idx_i : ~index_o;
    end
  end

  // ==========================================================
  // Count moved bytes
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      served_o <= 4'h0;
      beats_o  <= 4'h0;
      dir_o    <= 1'b0;
    end
    else if (fire_i)
    begin
      served_o <= 4'h0;
      beats_o  <= 4'h0;
    end
    else
    begin
      served_o <= served_o + {3'h0, serve_i};
      beats_o  <= beats_o + {3'h0, req_i};
      if (req_i)
        dir_o <= dir_i;
    end
  end
endmodule

// >>> sim/dcr_dma_cfg_regs_test.sv
// Self-checking bench for the DMA channel configuration registers
module dcr_dma_cfg_regs_test
  import dcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Stimulus and observed signals
  logic                  clk = 1'b0;
  logic                  nrst;
  logic [DCR_ADDR_W-1:0] addr;
  logic                  rd_en;
  logic                  wr_en;
  logic [31:0]           wdata;
  logic [3:0]            be;
  logic [7:0]            low;
  logic                  fire;
  logic [3:0]            fidx;
  logic [31:0]           rdata;
  logic                  waitreq;
  dcr_cfg_t              cfg;
  logic                  wrap;
  logic                  serve;
  logic [2:0]            bcnt;
  logic                  xreq;
  logic                  xdir;
  logic                  strobe;
  logic [3:0]            sidx;
  logic [3:0]            served;
  logic [3:0]            beats;
  logic                  pdir;
  int                    n_errors = 0;
  int                    comparisons = 0;
  logic [31:0]           seed = 32'h0000_1cec;
  logic [31:0]           q;
  logic [7:0]            d;
  logic [13:0]           mask;
  logic                  en;

  always #10 clk = ~clk;

  dcr_dma_cfg_regs DUT (.REF_CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(be), .SLOT_LOW_I(low), .SLOT_STROBE_I(strobe),
    .SLOT_INDEX_I(sidx), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .CFG_O(cfg), .MGR_WRAP_O(wrap), .SLOT_SERVE_O(serve), .BYTE_COUNT_O(bcnt),
    .XFER_REQ_O(xreq), .XFER_DIR_O(xdir));

  dcr_far_model far (.clk_i(clk), .rst_n_i(nrst), .fire_i(fire), .idx_i(fidx),
    .serve_i(serve), .req_i(xreq), .dir_i(xdir), .strobe_o(strobe),
    .index_o(sidx), .served_o(served), .beats_o(beats), .dir_o(pdir));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Reserved control bits never read back
  function automatic logic [31:0] exp_ctl(input logic [7:0] v);
    return {24'h00_0000, v & 8'hcf};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] v,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= a;
    wdata <= {24'h00_0000, v};
    be    <= b;
    wr_en <= w;
    rd_en <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      n_errors++;
      $display("mismatch bus expected answer seen timeout");
    end
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic slot(input logic [3:0] i, input logic [2:0] n, input logic dr);
    @(posedge clk);
    fire <= 1'b1;
    fidx <= i;
    @(posedge clk);
    fire <= 1'b0;
    repeat (8) @(posedge clk);
    chk("served", {31'h0, n != 3'h0}, {28'h000_0000, served});
    chk("beats", {29'h0, n}, {28'h000_0000, beats});
    if (n != 3'h0)
      chk("dir", {31'h0, dr}, {31'h0, pdir});
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end

  // ==========================================================
  // Tests
  initial
  begin
    {nrst, addr, rd_en, wr_en, wdata, be, low, fire, fidx} = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, DCR_CTL_ADDR, 8'h00, 4'hf);
    chk("ctl reset", 32'h0000_0000, q);
    bus(1'b0, DCR_HI_ADDR, 8'h00, 4'hf);
    chk("hi reset", 32'h0000_0000, q);
    chk("cfg reset", 32'h0000_0000, {10'h000, cfg});
    $display("test reset done");
    // Software picks endpoints 1-7 only, channel kept off
    repeat (16)
    begin
      seed = lfsr(seed);
      d = seed[7:0] & 8'h7f;
      if (d[2:0] == 3'h0)
        d[0] = 1'b1;
      bus(1'b1, DCR_CTL_ADDR, d, 4'hf);
      bus(1'b1, DCR_CTL_ADDR, ~d, 4'he);
      bus(1'b0, DCR_CTL_ADDR, 8'h00, 4'hf);
      chk("ctl", exp_ctl(d), q);
      chk("wrap", {31'h0, d[6]}, {31'h0, cfg.wrap_en});
      chk("mgr wrap", {31'h0, d[6]}, {31'h0, wrap});
      chk("dir", {31'h0, d[3]}, {31'h0, cfg.ep_dir});
      chk("ep", {29'h0, d[2:0]}, {29'h0, cfg.ep_num});
      chk("xdir", {31'h0, d[3]}, {31'h0, xdir});
    end
    bus(1'b1, 18'h0_0010, 8'hff, 4'hf);
    bus(1'b0, 18'h0_0010, 8'h00, 4'hf);
    chk("unmapped", 32'h0000_0000, q);
    $display("test control done");
    for (int k = 0; k < 5; k++)
    begin
      seed = lfsr(seed);
      en = (k != 0);
      // Channel off while its slots and byte count change
      bus(1'b1, DCR_CTL_ADDR, 8'h00, 4'hf);
      low <= seed[7:0];
      mask = {seed[13:8], seed[7:0]};
      bus(1'b1, DCR_HI_ADDR, {k[1:0], mask[13:8]}, 4'hf);
      bus(1'b0, DCR_HI_ADDR, 8'h00, 4'hf);
      chk("hi", {24'h00_0000, k[1:0], mask[13:8]}, q);
      chk("slot hi", {26'h0, mask[13:8]}, {26'h0, cfg.slot_mask[13:8]});
      chk("slot lo", {24'h00_0000, mask[7:0]}, {24'h00_0000, cfg.slot_mask[7:0]});
      chk("bytes code", {30'h0, k[1:0]}, {30'h0, cfg.bytes_code});
      chk("bytes", {29'h0, 3'(k[1:0]) + 3'h1}, {29'h0, bcnt});
      // Reserved bits written high on purpose
      bus(1'b1, DCR_CTL_ADDR, {en, 1'b1, 2'b11, k[0], 3'h5}, 4'hf);
      // The write lands at the answer edge, so look one edge later
      @(posedge clk);
      chk("en", {31'h0, en}, {31'h0, cfg.chan_en});
      for (int i = 0; i < 16; i++)
        slot(4'(i), (en && i < 14 && mask[i]) ? 3'(k[1:0]) + 3'h1 : 3'h0, k[0]);
    end
    $display("test serve done");
    summarize();
  end
endmodule
